//--- usb_interrupt_control.sv
`timescale 1ns/1ps
// Behaviour
// - usb_irq_mask bit one masks its source; bits 7,6,4,3,2,1,0 as listed.
// - bit 5 of usb registers and bits 7..4 of suspend registers read zero.
// - writing one to usb_irq_acknowledge clears that usb status bit.
// - usb_irq_enable bit one enables its source, same layout as mask.
// - with separation active, a detected bus reset sets status bit 3.
// - remote wakeup event sets status bit 2; interrupts when enabled.
// - resume on a port other than port 1 sets status bit 1.
// - global suspend sets status bit 0; interrupts when enabled.
// - separated bus reset (se0 over 3 ms) resets usb logic only, interrupts core.
// - each suspend enable bit interrupts when its status bit is set.
// - suspend mask bit one makes enabled event visible, zero hides it.
// - separation active only when enable bit 3 and mask bit 3 are both one.
// - late frame point set before frame; start of frame set on valid packet.
// - writing zero to a suspend status bit clears it.
module usb_interrupt_control #(
  parameter int BUS_RESET_CYCLES = usb_irq_pkg::BUS_RESET_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sof_received,
  input wire logic late_frame_point,
  input wire logic hub_control_endpoint,
  input wire logic function_endpoint_zero,
  input wire logic function_endpoint_one,
  input wire logic function_endpoint_two,
  input wire logic function_endpoint_three,
  input wire logic remote_wakeup_event,
  input wire logic [3:0] port_resume_event,
  input wire logic global_suspend_event,
  input wire logic bus_se0,
  output logic usb_hw_reset,
  output logic bus_reset_to_core,
  output logic usb_irq,
  output logic suspend_resume_irq,
  output logic irq
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] usb_irq_enable;
  logic [7:0] usb_irq_mask;
  logic [7:0] usb_irq_status;
  logic [7:0] suspend_resume_mask;
  logic [7:0] suspend_resume_enable;
  logic [7:0] suspend_resume_status;
  logic [7:0] usb_events;
  logic [7:0] sr_events;
  logic separation;
  logic bus_reset_seen;
  logic [31:0] se0_count;
  logic wr;
  logic rd;

  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  assign usb_events = {sof_received, late_frame_point, 1'b0, function_endpoint_three,
                       hub_control_endpoint, function_endpoint_two,
                       function_endpoint_one, function_endpoint_zero};

  assign separation = suspend_resume_enable[usb_irq_pkg::SR_BUS_RESET_BIT] &&
                      suspend_resume_mask[usb_irq_pkg::SR_BUS_RESET_BIT];

  always_comb begin
    sr_events = 8'h00;
    sr_events[usb_irq_pkg::SR_BUS_RESET_BIT] = separation && bus_reset_seen;
    sr_events[usb_irq_pkg::SR_REMOTE_WAKEUP_BIT] = remote_wakeup_event;
    sr_events[usb_irq_pkg::SR_RESUME_BIT] = |{port_resume_event[3:2], port_resume_event[0]};
    sr_events[usb_irq_pkg::SR_GLOBAL_SUSPEND_BIT] = global_suspend_event;
  end

  // ---------------------------------------------------------------
  // bus reset detection: se0 held for the minimum time
  // ---------------------------------------------------------------
  // counter saturates so a long se0 yields a single detection pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_count <= 32'h0;
    end else if (!bus_se0) begin
      se0_count <= 32'h0;
    end else if (se0_count < 32'(BUS_RESET_CYCLES)) begin
      se0_count <= se0_count + 32'h1;
    end
  end

  assign bus_reset_seen = bus_se0 && (se0_count == 32'(BUS_RESET_CYCLES) - 32'h1);

  // with separation the core is spared; otherwise the reset goes to the core too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_hw_reset <= 1'b0;
      bus_reset_to_core <= 1'b0;
    end else begin
      usb_hw_reset <= bus_reset_seen;
      bus_reset_to_core <= bus_reset_seen && !separation;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_irq_enable <= usb_irq_pkg::REG_RESET;
    end else if (wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_ENABLE)) begin
      usb_irq_enable <= pwdata[7:0] & usb_irq_pkg::USB_IMPL_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_irq_mask <= usb_irq_pkg::REG_RESET;
    end else if (wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_MASK)) begin
      usb_irq_mask <= pwdata[7:0] & usb_irq_pkg::USB_IMPL_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_resume_mask <= usb_irq_pkg::REG_RESET;
    end else if (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_MASK)) begin
      suspend_resume_mask <= pwdata[7:0] & usb_irq_pkg::SR_IMPL_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_resume_enable <= usb_irq_pkg::REG_RESET;
    end else if (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_ENABLE)) begin
      suspend_resume_enable <= pwdata[7:0] & usb_irq_pkg::SR_IMPL_BITS;
    end
  end

  // ---------------------------------------------------------------
  // status registers: set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_irq_status <= usb_irq_pkg::REG_RESET;
    end else if (wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_ACKNOWLEDGE)) begin
      usb_irq_status <= ((usb_irq_status & ~pwdata[7:0]) | usb_events)
                        & usb_irq_pkg::USB_IMPL_BITS;
    end else begin
      usb_irq_status <= (usb_irq_status | usb_events) & usb_irq_pkg::USB_IMPL_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_resume_status <= usb_irq_pkg::REG_RESET;
    end else if (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_STATUS)) begin
      suspend_resume_status <= ((suspend_resume_status & pwdata[7:0]) | sr_events)
                               & usb_irq_pkg::SR_IMPL_BITS;
    end else begin
      suspend_resume_status <= (suspend_resume_status | sr_events)
                               & usb_irq_pkg::SR_IMPL_BITS;
    end
  end

  // ---------------------------------------------------------------
  // interrupt outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_irq <= 1'b0;
      suspend_resume_irq <= 1'b0;
    end else begin
      usb_irq <= |(usb_irq_status & usb_irq_enable & ~usb_irq_mask);
      suspend_resume_irq <= |(suspend_resume_status & suspend_resume_enable
                              & suspend_resume_mask);
    end
  end

  assign irq = usb_irq || suspend_resume_irq;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reserved bits never stored, so they read zero; unmapped reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (hit(paddr, usb_irq_pkg::IDX_USB_IRQ_ENABLE)) begin
        prdata <= {24'h0, usb_irq_enable};
      end else if (hit(paddr, usb_irq_pkg::IDX_USB_IRQ_MASK)) begin
        prdata <= {24'h0, usb_irq_mask};
      end else if (hit(paddr, usb_irq_pkg::IDX_USB_IRQ_STATUS)) begin
        prdata <= {24'h0, usb_irq_status};
      end else if (hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_ENABLE)) begin
        prdata <= {24'h0, suspend_resume_enable};
      end else if (hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_STATUS)) begin
        prdata <= {24'h0, suspend_resume_status};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_usb_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 usb_irq == $past(|(usb_irq_status & usb_irq_enable & ~usb_irq_mask)))
    else $error("usb irq level wrong");
  a_sr_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 suspend_resume_irq == $past(|(suspend_resume_status & suspend_resume_enable
                                      & suspend_resume_mask)))
    else $error("suspend irq level wrong");
  a_ack_clears_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_ACKNOWLEDGE) && pwdata[0]
     && !function_endpoint_zero) |=> !usb_irq_status[0])
    else $error("acknowledge did not clear");
  a_sr_zero_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_STATUS) && !pwdata[0]
     && !global_suspend_event) |=> !suspend_resume_status[0])
    else $error("zero write did not clear");
  a_wakeup_sets: assert property (@(posedge pclk) disable iff (!presetn)
    remote_wakeup_event |=> suspend_resume_status[usb_irq_pkg::SR_REMOTE_WAKEUP_BIT])
    else $error("wakeup not recorded");
  a_resume_port1: assert property (@(posedge pclk) disable iff (!presetn)
    (port_resume_event[1] && !suspend_resume_status[1] && port_resume_event[3:2] == 2'b00
     && !port_resume_event[0]) |=> !suspend_resume_status[1])
    else $error("port 1 resume set status");
  a_suspend_sets: assert property (@(posedge pclk) disable iff (!presetn)
    global_suspend_event |=> suspend_resume_status[0])
    else $error("suspend not recorded");
  a_bus_int_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!separation && !suspend_resume_status[3]) |=> !suspend_resume_status[3])
    else $error("bus int without separation");
  a_core_spared: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_reset_seen && separation) |=> (usb_hw_reset && !bus_reset_to_core))
    else $error("core reset during separation");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    usb_irq_status[5] == 1'b0 && suspend_resume_status[7:4] == 4'h0)
    else $error("reserved bit set");

  // ---------------------------------------------------------------
  // register and event checks
  // ---------------------------------------------------------------
  a_enable_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    usb_irq_enable[5] == 1'b0 && usb_irq_mask[5] == 1'b0
    && suspend_resume_enable[7:4] == 4'h0 && suspend_resume_mask[7:4] == 4'h0)
    else $error("reserved control bit set");

  a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h0)
    else $error("read data upper bits set");

  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_ENABLE))
    |=> usb_irq_enable == ($past(pwdata[7:0]) & usb_irq_pkg::USB_IMPL_BITS))
    else $error("usb enable write lost");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_MASK))
    |=> usb_irq_mask == ($past(pwdata[7:0]) & usb_irq_pkg::USB_IMPL_BITS))
    else $error("usb mask write lost");

  a_sr_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_ENABLE))
    |=> suspend_resume_enable == ($past(pwdata[7:0]) & usb_irq_pkg::SR_IMPL_BITS))
    else $error("suspend enable write lost");

  a_sr_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_MASK))
    |=> suspend_resume_mask == ($past(pwdata[7:0]) & usb_irq_pkg::SR_IMPL_BITS))
    else $error("suspend mask write lost");

  a_sof_sets: assert property (@(posedge pclk) disable iff (!presetn)
    sof_received
    |=> usb_irq_status[7])
    else $error("start of frame not recorded");

  a_late_frame_sets: assert property (@(posedge pclk) disable iff (!presetn)
    late_frame_point
    |=> usb_irq_status[6])
    else $error("late frame point not recorded");

  a_ep_three_sets: assert property (@(posedge pclk) disable iff (!presetn)
    function_endpoint_three
    |=> usb_irq_status[4])
    else $error("endpoint three not recorded");

  a_hub_ep_sets: assert property (@(posedge pclk) disable iff (!presetn)
    hub_control_endpoint
    |=> usb_irq_status[3])
    else $error("hub endpoint not recorded");

  a_ep_two_sets: assert property (@(posedge pclk) disable iff (!presetn)
    function_endpoint_two
    |=> usb_irq_status[2])
    else $error("endpoint two not recorded");

  a_ep_one_sets: assert property (@(posedge pclk) disable iff (!presetn)
    function_endpoint_one
    |=> usb_irq_status[1])
    else $error("endpoint one not recorded");

  a_ep_zero_sets: assert property (@(posedge pclk) disable iff (!presetn)
    function_endpoint_zero
    |=> usb_irq_status[0])
    else $error("endpoint zero not recorded");

  a_resume_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (port_resume_event[0] || port_resume_event[2] || port_resume_event[3])
    |=> suspend_resume_status[1])
    else $error("resume not recorded");

  a_bus_reset_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_reset_seen && separation)
    |=> suspend_resume_status[3])
    else $error("bus reset not recorded");

  a_core_reset_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_reset_seen && !separation)
    |=> (usb_hw_reset && bus_reset_to_core))
    else $error("bus reset did not reach core");

  a_no_spurious_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !bus_reset_seen
    |=> (!usb_hw_reset && !bus_reset_to_core))
    else $error("reset pulse without detection");

  a_usb_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr && usb_events == 8'h00)
    |=> usb_irq_status == $past(usb_irq_status))
    else $error("usb status changed on its own");

  a_sr_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr && sr_events == 8'h00)
    |=> suspend_resume_status == $past(suspend_resume_status))
    else $error("suspend status changed on its own");

  a_sr_one_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_STATUS) && pwdata[3:0] == 4'hF)
    |=> (suspend_resume_status & $past(suspend_resume_status)) == $past(suspend_resume_status))
    else $error("one write cleared a suspend bit");

  a_read_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && usb_events == 8'h00)
    |=> (usb_irq_status == $past(usb_irq_status) && usb_irq_enable == $past(usb_irq_enable)))
    else $error("read changed register state");

  a_usb_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (usb_irq_enable == 8'h00)
    |=> !usb_irq)
    else $error("usb irq without enable");

  a_usb_all_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (usb_irq_mask == usb_irq_pkg::USB_IMPL_BITS)
    |=> !usb_irq)
    else $error("usb irq while all masked");

  a_sr_needs_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (suspend_resume_mask == 8'h00)
    |=> !suspend_resume_irq)
    else $error("suspend irq while hidden");

  c_ack_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, usb_irq_pkg::IDX_USB_IRQ_ACKNOWLEDGE));
  c_sr_clear: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, usb_irq_pkg::IDX_SUSPEND_RESUME_STATUS) && pwdata[3:0] != 4'hF);

  c_usb_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(usb_irq));
  c_sr_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(suspend_resume_irq));
  c_bus_reset: cover property (@(posedge pclk) disable iff (!presetn)
    bus_reset_seen && separation);

endmodule

//--- usb_irq_pkg.sv
package usb_irq_pkg;

  // ---------------------------------------------------------------
  // register indices (printed offsets are not word aligned)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_USB_IRQ_ENABLE = 16'h1FF3;
  localparam logic [15:0] IDX_USB_IRQ_STATUS = 16'h1FF7;
  localparam logic [15:0] IDX_USB_IRQ_ACKNOWLEDGE = 16'h1FF5;
  localparam logic [15:0] IDX_USB_IRQ_MASK = 16'h1FF6;
  localparam logic [15:0] IDX_SUSPEND_RESUME_MASK = 16'h1FF8;
  localparam logic [15:0] IDX_SUSPEND_RESUME_ENABLE = 16'h1FF9;
  localparam logic [15:0] IDX_SUSPEND_RESUME_STATUS = 16'h1FFA;

  localparam int ADDR_W = 18;

  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] USB_IMPL_BITS = 8'hDF;
  localparam logic [7:0] SR_IMPL_BITS = 8'h0F;
  localparam int SR_BUS_RESET_BIT = 3;
  localparam int SR_REMOTE_WAKEUP_BIT = 2;
  localparam int SR_RESUME_BIT = 1;
  localparam int SR_GLOBAL_SUSPEND_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // bus reset timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BUS_RESET_MIN_US = 3000;
  localparam int BUS_RESET_CYCLES = (CLK_HZ / 1_000_000) * BUS_RESET_MIN_US + 1;

endpackage

//--- usb_event_source.sv
`timescale 1ns/1ps
// -----------------------------------------
// hub side event generator
// -----------------------------------------
module usb_event_source (
  input wire logic pclk,
  output logic [7:0] usb_ev,
  output logic [3:0] port_resume,
  output logic remote_wakeup,
  output logic global_suspend,
  output logic se0
);
  initial begin
    usb_ev = 8'h00;
    port_resume = 4'h0;
    remote_wakeup = 1'b0;
    global_suspend = 1'b0;
    se0 = 1'b0;
  end
  // one-cycle pulses, as the frame timer and end-point logic give them
  task automatic fire(input logic [7:0] u, input logic [3:0] p, input logic [1:0] s);
    @(posedge pclk);
    usb_ev <= u;
    port_resume <= p;
    remote_wakeup <= s[1];
    global_suspend <= s[0];
    @(posedge pclk);
    usb_ev <= 8'h00;
    port_resume <= 4'h0;
    remote_wakeup <= 1'b0;
    global_suspend <= 1'b0;
  endtask
  task automatic bus_reset(input int n);
    @(posedge pclk);
    se0 <= 1'b1;
    repeat (n) @(posedge pclk);
    se0 <= 1'b0;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int BRC = 8;
  localparam logic [17:0] A_EN = {usb_irq_pkg::IDX_USB_IRQ_ENABLE, 2'b00};
  localparam logic [17:0] A_ST = {usb_irq_pkg::IDX_USB_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_ACK = {usb_irq_pkg::IDX_USB_IRQ_ACKNOWLEDGE, 2'b00};
  localparam logic [17:0] A_MSK = {usb_irq_pkg::IDX_USB_IRQ_MASK, 2'b00};
  localparam logic [17:0] A_SRM = {usb_irq_pkg::IDX_SUSPEND_RESUME_MASK, 2'b00};
  localparam logic [17:0] A_SRE = {usb_irq_pkg::IDX_SUSPEND_RESUME_ENABLE, 2'b00};
  localparam logic [17:0] A_SRS = {usb_irq_pkg::IDX_SUSPEND_RESUME_STATUS, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic usb_hw_reset, bus_reset_to_core, usb_irq, suspend_resume_irq, irq;
  logic [7:0] usb_ev;
  logic [3:0] port_resume;
  logic remote_wakeup, global_suspend, se0;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_hw = 0;
  int n_core = 0;
  usb_event_source u_src (.pclk(pclk), .usb_ev(usb_ev), .port_resume(port_resume),
    .remote_wakeup(remote_wakeup), .global_suspend(global_suspend), .se0(se0));
  usb_interrupt_control #(.BUS_RESET_CYCLES(BRC)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sof_received(usb_ev[7]),
    .late_frame_point(usb_ev[6]), .hub_control_endpoint(usb_ev[3]),
    .function_endpoint_zero(usb_ev[0]), .function_endpoint_one(usb_ev[1]),
    .function_endpoint_two(usb_ev[2]), .function_endpoint_three(usb_ev[4]),
    .remote_wakeup_event(remote_wakeup), .port_resume_event(port_resume),
    .global_suspend_event(global_suspend), .bus_se0(se0), .usb_hw_reset(usb_hw_reset),
    .bus_reset_to_core(bus_reset_to_core), .usb_irq(usb_irq),
    .suspend_resume_irq(suspend_resume_irq), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // the ceiling is far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    n_hw += (usb_hw_reset === 1'b1);
    n_core += (bus_reset_to_core === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_usb;
    apb(1'b1, A_EN, 32'hFF);
    apb(1'b0, A_EN, 32'h0);
    check("enable", rd, 32'hDF);
    for (int b = 0; b < 8; b++) begin
      if (b != 5) begin
        u_src.fire(8'h01 << b, 4'h0, 2'b00);
        repeat (2) @(posedge pclk);
        check("usb_irq", usb_irq, 1'b1);
        check("irq", irq, 1'b1);
        apb(1'b0, A_ST, 32'h0);
        check("status", rd, 32'h1 << b);
        apb(1'b1, A_ACK, 32'h1 << b);
        repeat (2) @(posedge pclk);
        check("usb_irq", usb_irq, 1'b0);
      end
    end
    apb(1'b1, A_MSK, 32'hFF);
    apb(1'b0, A_MSK, 32'h0);
    check("mask", rd, 32'hDF);
    u_src.fire(8'hDF, 4'h0, 2'b00);
    repeat (2) @(posedge pclk);
    check("usb_irq", usb_irq, 1'b0);
    apb(1'b0, A_ST, 32'h0);
    check("status", rd, 32'hDF);
    apb(1'b1, A_MSK, 32'hBF);
    repeat (2) @(posedge pclk);
    check("usb_irq", usb_irq, 1'b1);
    apb(1'b1, A_ACK, 32'hDF);
    apb(1'b0, A_ST, 32'h0);
    check("status", rd, 32'h0);
    apb(1'b1, A_EN, 32'h0);
    apb(1'b1, A_MSK, 32'h0);
    u_src.fire(8'hDF, 4'h0, 2'b00);
    repeat (2) @(posedge pclk);
    check("usb_irq", usb_irq, 1'b0);
    apb(1'b1, A_ACK, 32'hFF);
    $display("usb group test done");
  endtask
  task automatic t_sr;
    apb(1'b1, A_SRE, 32'hF7);
    apb(1'b1, A_SRM, 32'hF7);
    apb(1'b0, A_SRM, 32'h0);
    check("sr mask", rd, 32'h0);
    for (int b = 0; b < 3; b++) begin
      u_src.fire(8'h00, (b == 1) ? 4'h4 : 4'h0, {b == 2, b == 0});
      repeat (2) @(posedge pclk);
      check("sr irq", suspend_resume_irq, 1'b1);
      apb(1'b0, A_SRS, 32'h0);
      check("sr status", rd, 32'h1 << b);
      apb(1'b1, A_SRS, 32'h0F ^ (32'h1 << b));
      repeat (2) @(posedge pclk);
      check("sr irq", suspend_resume_irq, 1'b0);
    end
    u_src.fire(8'h00, 4'h2, 2'b00);
    apb(1'b0, A_SRS, 32'h0);
    check("sr status", rd, 32'h0);
    apb(1'b1, A_SRM, 32'h06);
    u_src.fire(8'h00, 4'h0, 2'b01);
    repeat (2) @(posedge pclk);
    check("sr irq", suspend_resume_irq, 1'b0);
    apb(1'b1, A_SRM, 32'h07);
    repeat (2) @(posedge pclk);
    check("sr irq", suspend_resume_irq, 1'b1);
    apb(1'b1, A_SRE, 32'h06);
    repeat (2) @(posedge pclk);
    check("sr irq", suspend_resume_irq, 1'b0);
    apb(1'b1, A_SRS, 32'h0);
    $display("suspend group test done");
  endtask
  task automatic t_bus(input logic [31:0] en, input int core, input logic [31:0] st);
    apb(1'b1, A_SRE, en);
    apb(1'b1, A_SRM, 32'h08);
    n_hw = 0;
    n_core = 0;
    u_src.bus_reset(BRC + 4);
    repeat (3) @(posedge pclk);
    check("hw resets", n_hw, 1);
    check("core resets", n_core, core);
    apb(1'b0, A_SRS, 32'h0);
    check("sr status", rd, st);
    check("sr irq", suspend_resume_irq, st[3]);
    apb(1'b1, A_SRS, 32'h0);
    $display("bus reset test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_EN, 32'h0);
    check("enable rst", rd, 32'h0);
    apb(1'b0, A_SRS, 32'h0);
    check("sr rst", rd, 32'h0);
    apb(1'b0, 18'h00100, 32'h0);
    check("unmapped", rd, 32'h0);
    check("pslverr", pslverr, 1'b0);
    check("pready", pready, 1'b1);
    t_usb();
    t_sr();
    t_bus(32'h00, 1, 32'h0);
    t_bus(32'h08, 0, 32'h8);
    conclude();
  end
endmodule
